/* File: design/twsp_pkg.sv */
package twsp_pkg;

  // Bus timing: the fastest serial clock the target accepts sets the quarter period.
  localparam int CLK_PERIOD_NS     = 10;
  localparam int SCL_MIN_PERIOD_NS = 2500;
  localparam int QUARTER_CYC       =
    (SCL_MIN_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam int FILT_LEN          = 3;
  localparam int RETRY_MAX         = 2;

  // Software register indices.
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_TARGET  = 4'h1;
  localparam logic [3:0] REG_POINTER = 4'h2;
  localparam logic [3:0] REG_COUNT   = 4'h3;
  localparam logic [3:0] REG_WDATA   = 4'h4;
  localparam logic [3:0] REG_RDATA   = 4'h5;
  localparam logic [3:0] REG_STATUS  = 4'h6;

  // Field positions.
  localparam int CTRL_WRITE_BIT = 0;
  localparam int CTRL_READ_BIT  = 1;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_DONE_BIT  = 1;
  localparam int STAT_NACK_BIT  = 2;

  // Reset values and target map.
  localparam logic [6:0] TARGET_RESET   = 7'h59;
  localparam logic [7:0] SLAVE_ADDR_PTR = 8'h80;
  localparam logic [2:0] COUNT_RESET    = 3'h1;
  localparam logic [2:0] COUNT_MAX      = 3'h4;
  localparam logic       DIR_WRITE      = 1'b0;
  localparam logic       DIR_READ       = 1'b1;
  localparam logic [3:0] BIT_ACK        = 4'h8;

  // Quarter phases of one serial clock period.
  localparam logic [1:0] PH0 = 2'h0;
  localparam logic [1:0] PH1 = 2'h1;
  localparam logic [1:0] PH2 = 2'h2;
  localparam logic [1:0] PH3 = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BYTE, ST_STOP} twsp_state_e;
  typedef enum logic [2:0] {STG_ADDR_W, STG_PTR, STG_WDATA, STG_ADDR_R, STG_RDATA} twsp_stage_e;

endpackage

/* File: design/twsp_pin_filter.sv */
module twsp_pin_filter #(
  parameter int FILT_LEN = 3
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic pin,
  output logic      level
);

  localparam int CW = $clog2(FILT_LEN + 1);

  logic          sync1_reg;
  logic          sync2_reg;
  logic [CW-1:0] count_reg;
  logic          level_reg;

  // Idle bus level is high, so the chain resets high.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
    end
  end

  // A new level is taken only after it has stood for FILT_LEN cycles.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0;
      level_reg <= 1'b1;
    end else if (sync2_reg == level_reg) begin
      count_reg <= '0;
    end else if (count_reg == CW'(FILT_LEN - 1)) begin
      count_reg <= '0;
      level_reg <= sync2_reg;
    end else begin
      count_reg <= count_reg + CW'(1);
    end
  end

  assign level = level_reg;

endmodule

/* File: design/twsp_quarter_tick.sv */
module twsp_quarter_tick #(
  parameter int QUARTER_CYC = 63
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic run,
  output logic      tick
);

  localparam int CW = $clog2(QUARTER_CYC + 1);

  logic [CW-1:0] count_reg;
  logic          tick_reg;

  // Restarting on every run keeps the first quarter of a frame full length.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0;
      tick_reg  <= 1'b0;
    end else if (!run) begin
      count_reg <= '0;
      tick_reg  <= 1'b0;
    end else if (count_reg == CW'(QUARTER_CYC - 1)) begin
      count_reg <= '0;
      tick_reg  <= 1'b1;
    end else begin
      count_reg <= count_reg + CW'(1);
      tick_reg  <= 1'b0;
    end
  end

  assign tick = tick_reg;

endmodule

/* File: design/twsp_host.sv */
// What this block does
// - Serial clock runs no faster than 400 kHz, with no per-speed setup.
// - This master makes the serial clock and every START and STOP.
// - One bit per clock period; data changes only while the clock is low.
// - START is data falling with clock high; STOP is data rising with clock high.
// - A read turns around with a repeated START instead of STOP plus START.
// - A frame starts only with both lines high; STOP returns the bus to idle.
// - Acknowledge pulls data low across the ninth clock high period.
// - Not-acknowledge leaves data released across the ninth clock.
// - A missing acknowledge ends the frame and the whole frame is retried, up to RETRY_MAX times per command.
// - Bytes go eight bits MSB first, then the acknowledge bit.
// - Direction bit 0 writes, 1 reads.
// - A read ends with not-acknowledge on the last byte wanted.
module twsp_host #(
  parameter int QUARTER_CYC = twsp_pkg::QUARTER_CYC,
  parameter int FILT_LEN    = twsp_pkg::FILT_LEN,
  parameter int RETRY_MAX   = twsp_pkg::RETRY_MAX
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  sw_addr,
  input  wire logic [31:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic      [31:0] sw_rdata,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe
);

  twsp_pkg::twsp_state_e state_reg;
  twsp_pkg::twsp_state_e state_next;
  twsp_pkg::twsp_stage_e stage_reg;
  twsp_pkg::twsp_stage_e stage_next;

  logic [1:0]  phase_reg;
  logic [1:0]  phase_next;
  logic [3:0]  bit_reg;
  logic [3:0]  bit_next;
  logic [7:0]  shift_reg;
  logic [7:0]  shift_next;
  logic [31:0] word_reg;
  logic [31:0] word_next;
  logic [2:0]  left_reg;
  logic [2:0]  left_next;
  logic        nack_seen_reg;
  logic        nack_seen_next;
  logic        sda_oe_reg;
  logic        sda_oe_next;
  logic        scl_oe_reg;
  logic        scl_oe_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        launch;
  logic        finish;
  logic        retry_go;

  logic        pending_reg;
  logic        read_mode_reg;
  logic [1:0]  retry_reg;
  logic        done_reg;
  logic        nack_reg;
  logic [6:0]  target_reg;
  logic [7:0]  pointer_reg;
  logic [2:0]  count_reg;
  logic [31:0] wdata_reg;
  logic [7:0]  first_reg;
  logic [31:0] sw_rdata_reg;
  logic        sda_out_reg;
  logic        scl_out_reg;

  wire logic sda_f;
  wire logic scl_f;
  wire logic tick;

  function automatic logic [7:0] addr_byte(input logic [6:0] a, input logic dir);
    addr_byte = {a, dir};
  endfunction

  // Left-justify the bytes in use so the most significant goes first.
  function automatic logic [31:0] tx_align(input logic [31:0] w, input logic [2:0] n);
    case (n)
      3'h1:    tx_align = {w[7:0], 24'h0000_00};
      3'h2:    tx_align = {w[15:0], 16'h0000};
      3'h3:    tx_align = {w[23:0], 8'h00};
      default: tx_align = w;
    endcase
  endfunction

  twsp_pin_filter #(.FILT_LEN(FILT_LEN)) u_sda_filt (
    .clk     (clk),
    .reset_n (reset_n),
    .pin     (sda_in),
    .level   (sda_f)
  );

  twsp_pin_filter #(.FILT_LEN(FILT_LEN)) u_scl_filt (
    .clk     (clk),
    .reset_n (reset_n),
    .pin     (scl_in),
    .level   (scl_f)
  );

  twsp_quarter_tick #(.QUARTER_CYC(QUARTER_CYC)) u_tick (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (state_reg != twsp_pkg::ST_IDLE),
    .tick    (tick)
  );

  wire logic busy      = pending_reg || (state_reg != twsp_pkg::ST_IDLE);
  wire logic bus_idle  = sda_f && scl_f;
  wire logic last_byte = (left_reg == 3'h1);
  wire logic is_rx     = (stage_reg == twsp_pkg::STG_RDATA);
  wire logic at_ack    = (bit_reg == twsp_pkg::BIT_ACK);
  // Pull low for a zero data bit, or for an acknowledge on any read byte but the last.
  wire logic drive_low = at_ack ? (is_rx && !last_byte) : (!is_rx && !shift_reg[7]);

  wire logic wr_ctrl   = sw_wr && (sw_addr == twsp_pkg::REG_CTRL);
  wire logic go        = wr_ctrl && !busy &&
                         (sw_wdata[twsp_pkg::CTRL_WRITE_BIT] || sw_wdata[twsp_pkg::CTRL_READ_BIT]);
  wire logic cfg_wr    = sw_wr && !busy;
  wire logic clr_flags = sw_wr && (sw_addr == twsp_pkg::REG_STATUS) &&
                         sw_wdata[twsp_pkg::STAT_DONE_BIT];
  wire logic [2:0] count_in = sw_wdata[2:0];
  wire logic [2:0] count_clamped = (count_in == 3'h0) ? 3'h1 :
                                   (count_in > twsp_pkg::COUNT_MAX) ? twsp_pkg::COUNT_MAX : count_in;
  // A successful write that starts at the address location retargets the very next frame.
  wire logic retarget  = finish && !nack_seen_reg && !read_mode_reg &&
                         (pointer_reg == twsp_pkg::SLAVE_ADDR_PTR);
  wire logic [31:0] tx_first = tx_align(wdata_reg, count_reg);

  wire logic [31:0] status_word = {26'h000_0000, retry_reg, 1'b0, nack_reg, done_reg, busy};
  wire logic [31:0] rd_mux =
    (sw_addr == twsp_pkg::REG_TARGET)  ? {25'h000_0000, target_reg} :
    (sw_addr == twsp_pkg::REG_POINTER) ? {24'h00_0000, pointer_reg} :
    (sw_addr == twsp_pkg::REG_COUNT)   ? {29'h0000_0000, count_reg} :
    (sw_addr == twsp_pkg::REG_WDATA)   ? wdata_reg :
    (sw_addr == twsp_pkg::REG_RDATA)   ? rdata_reg :
    (sw_addr == twsp_pkg::REG_STATUS)  ? status_word : 32'h0000_0000;

  always_comb begin
    state_next     = state_reg;
    stage_next     = stage_reg;
    phase_next     = phase_reg;
    bit_next       = bit_reg;
    shift_next     = shift_reg;
    word_next      = word_reg;
    left_next      = left_reg;
    nack_seen_next = nack_seen_reg;
    sda_oe_next    = sda_oe_reg;
    scl_oe_next    = scl_oe_reg;
    rdata_next     = rdata_reg;
    launch         = 1'b0;
    finish         = 1'b0;
    retry_go       = 1'b0;
    case (state_reg)
      twsp_pkg::ST_IDLE: begin
        if (pending_reg && bus_idle) begin
          launch         = 1'b1;
          state_next     = twsp_pkg::ST_START;
          stage_next     = twsp_pkg::STG_ADDR_W;
          phase_next     = twsp_pkg::PH0;
          shift_next     = addr_byte(target_reg, twsp_pkg::DIR_WRITE);
          word_next      = tx_align(wdata_reg, count_reg);
          left_next      = count_reg;
          nack_seen_next = 1'b0;
          rdata_next     = read_mode_reg ? 32'h0000_0000 : rdata_reg;
        end
      end
      twsp_pkg::ST_START: begin
        // From idle or from a low clock: release data, release clock, then pull data.
        if (tick) begin
          case (phase_reg)
            twsp_pkg::PH0: begin
              sda_oe_next = 1'b0;
              phase_next  = twsp_pkg::PH1;
            end
            twsp_pkg::PH1: begin
              scl_oe_next = 1'b0;
              phase_next  = twsp_pkg::PH2;
            end
            twsp_pkg::PH2: begin
              if (scl_f) begin
                sda_oe_next = 1'b1;
                phase_next  = twsp_pkg::PH3;
              end
            end
            default: begin
              scl_oe_next = 1'b1;
              phase_next  = twsp_pkg::PH0;
              bit_next    = 4'h0;
              state_next  = twsp_pkg::ST_BYTE;
            end
          endcase
        end
      end
      twsp_pkg::ST_BYTE: begin
        if (tick) begin
          case (phase_reg)
            twsp_pkg::PH0: begin
              sda_oe_next = drive_low;
              phase_next  = twsp_pkg::PH1;
            end
            twsp_pkg::PH1: begin
              phase_next = twsp_pkg::PH2;
            end
            twsp_pkg::PH2: begin
              scl_oe_next = 1'b0;
              phase_next  = twsp_pkg::PH3;
            end
            default: begin
              if (scl_f) begin
                scl_oe_next = 1'b1;
                phase_next  = twsp_pkg::PH0;
                if (!at_ack) begin
                  shift_next = {shift_reg[6:0], sda_f};
                  bit_next   = bit_reg + 4'h1;
                end else begin
                  bit_next = 4'h0;
                  if (is_rx) begin
                    rdata_next = {rdata_reg[23:0], shift_reg};
                    left_next  = left_reg - 3'h1;
                    if (last_byte) begin
                      state_next = twsp_pkg::ST_STOP;
                    end
                  end else if (sda_f) begin
                    nack_seen_next = 1'b1;
                    state_next     = twsp_pkg::ST_STOP;
                  end else begin
                    case (stage_reg)
                      twsp_pkg::STG_ADDR_W: begin
                        stage_next = twsp_pkg::STG_PTR;
                        shift_next = pointer_reg;
                      end
                      twsp_pkg::STG_PTR: begin
                        if (read_mode_reg) begin
                          stage_next = twsp_pkg::STG_ADDR_R;
                          state_next = twsp_pkg::ST_START;
                          shift_next = addr_byte(target_reg, twsp_pkg::DIR_READ);
                        end else begin
                          stage_next = twsp_pkg::STG_WDATA;
                          shift_next = word_reg[31:24];
                          word_next  = {word_reg[23:0], 8'h00};
                        end
                      end
                      twsp_pkg::STG_WDATA: begin
                        left_next  = left_reg - 3'h1;
                        shift_next = word_reg[31:24];
                        word_next  = {word_reg[23:0], 8'h00};
                        if (last_byte) begin
                          state_next = twsp_pkg::ST_STOP;
                        end
                      end
                      default: begin
                        stage_next = twsp_pkg::STG_RDATA;
                      end
                    endcase
                  end
                end
              end
            end
          endcase
        end
      end
      default: begin
        // Data low under a low clock, release clock, then release data.
        if (tick) begin
          case (phase_reg)
            twsp_pkg::PH0: begin
              sda_oe_next = 1'b1;
              phase_next  = twsp_pkg::PH1;
            end
            twsp_pkg::PH1: begin
              scl_oe_next = 1'b0;
              phase_next  = twsp_pkg::PH2;
            end
            twsp_pkg::PH2: begin
              if (scl_f) begin
                sda_oe_next = 1'b0;
                phase_next  = twsp_pkg::PH3;
              end
            end
            default: begin
              phase_next = twsp_pkg::PH0;
              state_next = twsp_pkg::ST_IDLE;
              if (nack_seen_reg && (retry_reg != 2'h0)) begin
                retry_go = 1'b1;
              end else begin
                finish = 1'b1;
              end
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg     <= twsp_pkg::ST_IDLE;
      stage_reg     <= twsp_pkg::STG_ADDR_W;
      phase_reg     <= twsp_pkg::PH0;
      bit_reg       <= 4'h0;
      shift_reg     <= 8'h00;
      word_reg      <= 32'h0000_0000;
      left_reg      <= 3'h0;
      nack_seen_reg <= 1'b0;
      sda_oe_reg    <= 1'b0;
      scl_oe_reg    <= 1'b0;
      rdata_reg     <= 32'h0000_0000;
    end else begin
      state_reg     <= state_next;
      stage_reg     <= stage_next;
      phase_reg     <= phase_next;
      bit_reg       <= bit_next;
      shift_reg     <= shift_next;
      word_reg      <= word_next;
      left_reg      <= left_next;
      nack_seen_reg <= nack_seen_next;
      sda_oe_reg    <= sda_oe_next;
      scl_oe_reg    <= scl_oe_next;
      rdata_reg     <= rdata_next;
    end
  end

  // Command, retry and completion flags; a completion beats a clear in the same cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pending_reg   <= 1'b0;
      read_mode_reg <= 1'b0;
      retry_reg     <= 2'h0;
      done_reg      <= 1'b0;
      nack_reg      <= 1'b0;
    end else begin
      pending_reg   <= go || retry_go || (pending_reg && !launch);
      read_mode_reg <= go ? sw_wdata[twsp_pkg::CTRL_READ_BIT] : read_mode_reg;
      retry_reg     <= go ? 2'(RETRY_MAX) : (retry_go ? retry_reg - 2'h1 : retry_reg);
      done_reg      <= finish || (done_reg && !clr_flags);
      nack_reg      <= (finish && nack_seen_reg) || (nack_reg && !clr_flags);
    end
  end

  // Setup registers ignore software writes while a frame is pending or running; target_reg can still be retargeted as the frame finishes.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      target_reg  <= twsp_pkg::TARGET_RESET;
      pointer_reg <= 8'h00;
      count_reg   <= twsp_pkg::COUNT_RESET;
      wdata_reg   <= 32'h0000_0000;
      first_reg   <= 8'h00;
    end else begin
      if (retarget) begin
        target_reg <= first_reg[7:1];
      end else if (cfg_wr && (sw_addr == twsp_pkg::REG_TARGET)) begin
        target_reg <= sw_wdata[6:0];
      end
      if (cfg_wr && (sw_addr == twsp_pkg::REG_POINTER)) begin
        pointer_reg <= sw_wdata[7:0];
      end
      if (cfg_wr && (sw_addr == twsp_pkg::REG_COUNT)) begin
        count_reg <= count_clamped;
      end
      if (cfg_wr && (sw_addr == twsp_pkg::REG_WDATA)) begin
        wdata_reg <= sw_wdata;
      end
      if (go) begin
        first_reg <= tx_first[31:24];
      end
    end
  end

  // Open-drain pins: the driven level is always low.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_rdata_reg <= 32'h0000_0000;
      sda_out_reg  <= 1'b0;
      scl_out_reg  <= 1'b0;
    end else begin
      sw_rdata_reg <= sw_rd ? rd_mux : 32'h0000_0000;
      sda_out_reg  <= 1'b0;
      scl_out_reg  <= 1'b0;
    end
  end

  assign sw_rdata = sw_rdata_reg;
  assign sda_out  = sda_out_reg;
  assign scl_out  = scl_out_reg;
  assign sda_oe   = sda_oe_reg;
  assign scl_oe   = scl_oe_reg;

endmodule

/* File: test/twsp_host_checker.sv */
module twsp_host_checker #(
  parameter int QUARTER_CYC = 63
) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [3:0]  sw_addr,
  input wire logic        sw_rd,
  input wire logic [31:0] sw_rdata,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_out,
  input wire logic        sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] run_reg;
  logic       prev_reg;
  logic       frame_reg;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // The run counter saturates so that a long idle never wraps into a short level.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_reg   <= 10'h000;
      prev_reg  <= 1'b0;
      frame_reg <= 1'b0;
    end else begin
      prev_reg <= scl_oe;
      if (scl_oe != prev_reg) run_reg <= 10'h000;
      else if (run_reg != 10'h3ff) run_reg <= run_reg + 10'h001;
      if ($rose(sda_oe) && !scl_oe) frame_reg <= 1'b1;
      else if ($fell(sda_oe) && !scl_oe) frame_reg <= 1'b0;
    end
  end
  pins_low_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("open-drain output level not low");
  rdata_quiet_a: assert property (!$past(sw_rd) |-> sw_rdata == 32'h0000_0000)
    else $error("read data not zero outside read cycle");
  ctrl_zero_a: assert property (sw_rd && sw_addr == twsp_pkg::REG_CTRL |=> sw_rdata == 32'h0)
    else $error("control register read not zero");
  unmapped_zero_a: assert property (sw_rd && sw_addr > twsp_pkg::REG_STATUS |=> sw_rdata == 32'h0)
    else $error("unmapped read not zero");
  lines_apart_a: assert property (!($changed(scl_oe) && $changed(sda_oe)))
    else $error("clock and data changed together");
  scl_level_min_a: assert property ($changed(scl_oe) |-> run_reg >= 10'(QUARTER_CYC - 1))
    else $error("serial clock level too short");
  clock_in_frame_a: assert property ($rose(scl_oe) |-> frame_reg)
    else $error("clock pulled low outside a frame");
  start_clock_a: assert property ($rose(sda_oe) && !scl_oe |-> ##[1:70] scl_oe)
    else $error("no clock after start");
  stop_idle_a: assert property ($fell(sda_oe) && !scl_oe |-> (!scl_oe && !sda_oe) [*4])
    else $error("bus not idle after stop");
endmodule

bind twsp_host twsp_host_checker #(.QUARTER_CYC(QUARTER_CYC)) u_chk (
  .clk(clk), .reset_n(reset_n), .sw_addr(sw_addr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe));

/* File: test/twsp_target_model.sv */
module twsp_target_model (
  input  wire logic clk,
  input  wire logic pwr_n,
  input  wire logic refuse,
  input  wire logic scl,
  input  wire logic sda,
  output logic      sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] sh, ptr;
  logic [6:0] addr;
  logic [3:0] cnt;
  logic [2:0] st;
  logic       ps, pd;
  int         starts = 0;
  // Power-up restores the default address 7'h59; the copy command is not modelled.
  always @(posedge clk or negedge pwr_n) begin
    if (!pwr_n) begin
      addr   <= 7'h59;
      st     <= 3'h4;
      sda_oe <= 1'b0;
      cnt    <= 4'hf;
      ps     <= 1'b1;
      pd     <= 1'b1;
    end else begin
      ps <= scl;
      pd <= sda;
      if (scl && ps && pd && !sda) begin
        st     <= 3'h0;
        cnt    <= 4'hf;
        starts <= starts + 1;
      end else if (scl && ps && !pd && sda) begin
        st     <= 3'h4;
        sda_oe <= 1'b0;
      end else if (scl && !ps) begin
        if (cnt < 8) sh <= {sh[6:0], sda};
        else if (st == 3 && sda) st <= 3'h4;
      end else if (!scl && ps) begin
        cnt    <= (cnt >= 8) ? 4'h0 : cnt + 4'h1;
        sda_oe <= 1'b0;
        if (cnt == 7) begin
          case (st)
            0: if (sh[7:1] == addr && !refuse) begin
              sda_oe <= 1'b1;
              st     <= sh[0] ? 3'h3 : 3'h1;
            end else st <= 3'h4;
            1: begin
              ptr    <= sh;
              sda_oe <= 1'b1;
              st     <= 3'h2;
            end
            2: begin
              mem[ptr] <= sh;
              if (ptr == 8'h80) addr <= sh[7:1];
              ptr    <= ptr + 8'h01;
              sda_oe <= 1'b1;
            end
            3: ptr <= ptr + 8'h01;
            default: ;
          endcase
        end else if (st == 3 && (cnt == 8 || cnt < 7)) begin
          sda_oe <= ~mem[ptr][cnt == 8 ? 7 : 6 - cnt];
        end
      end
    end
  end
endmodule

/* File: test/twsp_host_tb.sv */
module twsp_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, reset_n, sw_wr, sw_rd, pwr_n, refuse;
  logic [3:0]  sw_addr;
  logic [31:0] sw_wdata, sw_rdata, seed, v, d;
  logic        scl_out, scl_oe, sda_out, sda_oe, t_oe;
  logic [7:0]  p;
  logic [6:0]  na;
  logic [2:0]  n;
  int          mismatches, n_compared, cycles, s0;
  wire         scl_w = ~scl_oe;
  wire         sda_w = ~(sda_oe | t_oe);
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

  twsp_host #(.QUARTER_CYC(7), .FILT_LEN(3), .RETRY_MAX(1)) dut (
    .clk(clk), .reset_n(reset_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
  twsp_target_model tgt (.clk(clk), .pwr_n(pwr_n), .refuse(refuse), .scl(scl_w),
    .sda(sda_w), .sda_oe(t_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      close_out();
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] mask(input logic [2:0] k);
    return (k == 3'h4) ? 32'hffff_ffff : (32'h0000_0001 << (8 * k)) - 32'h0000_0001;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] x);
    @(posedge clk);
    sw_wr    <= 1'b1;
    sw_addr  <= a;
    sw_wdata <= x;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    sw_rd   <= 1'b1;
    sw_addr <= a;
    @(posedge clk);
    sw_rd <= 1'b0;
    @(negedge clk);
    v = sw_rdata;
  endtask
  task automatic load(input logic [7:0] pp, input logic [2:0] nn, input logic [31:0] dd);
    wr(twsp_pkg::REG_POINTER, {24'h00_0000, pp});
    wr(twsp_pkg::REG_COUNT, {29'h0, nn});
    wr(twsp_pkg::REG_WDATA, dd);
  endtask
  // The pointer write lands while busy, so a design that takes it reads or writes the wrong bytes.
  task automatic frame(input logic [31:0] c, input logic [2:0] es);
    int k;
    wr(twsp_pkg::REG_CTRL, c);
    wr(twsp_pkg::REG_POINTER, 32'h0000_00ff);
    k = 0;
    v = 32'h0;
    while (v[1] !== 1'b1 && k < 3000) begin
      rd(twsp_pkg::REG_STATUS);
      k++;
    end
    `CHK("status", es, v[2:0])
    wr(twsp_pkg::REG_STATUS, 32'h0000_0002);
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    reset_n  = 1'b0;
    pwr_n    = 1'b0;
    refuse   = 1'b0;
    sw_wr    = 1'b0;
    sw_rd    = 1'b0;
    sw_addr  = 4'h0;
    sw_wdata = 32'h0;
    seed     = 32'h0000_0046;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    pwr_n   <= 1'b1;
    rd(twsp_pkg::REG_TARGET);
    `CHK("target", 7'h59, v[6:0])
    rd(twsp_pkg::REG_STATUS);
    `CHK("status", 6'h00, v[5:0])
    rd(twsp_pkg::REG_CTRL);
    `CHK("ctrl", 32'h0, v)
    rd(4'hf);
    `CHK("unmapped", 32'h0, v)
    wr(twsp_pkg::REG_COUNT, 32'h0);
    rd(twsp_pkg::REG_COUNT);
    `CHK("count", 3'h1, v[2:0])
    wr(twsp_pkg::REG_COUNT, 32'h0000_0007);
    rd(twsp_pkg::REG_COUNT);
    `CHK("count_max", twsp_pkg::COUNT_MAX, v[2:0])
    $display("test reset_values done");
    for (int i = 0; i < 3; i++) begin
      d = xs();
      // A run of bytes that reaches the address location would retarget the model.
      p = (d[7:0] inside {[8'h7d:8'h80]}) ? 8'h81 : d[7:0];
      n = (i == 0) ? 3'h4 : {1'b0, d[9:8]} + 3'h1;
      d = xs() & mask(n);
      load(p, n, d);
      rd(twsp_pkg::REG_WDATA);
      `CHK("wdata", d, v)
      frame(32'h0000_0001, 3'b010);
      rd(twsp_pkg::REG_POINTER);
      `CHK("pointer", p, v[7:0])
      for (int k = 0; k < n; k++) `CHK("mem", d[8*(n-1-k) +: 8], tgt.mem[p + 8'(k)])
      frame(32'h0000_0002, 3'b010);
      rd(twsp_pkg::REG_RDATA);
      `CHK("rdata", d, v)
      $display("test frame %0d done", i);
    end
    d = xs();
    na = (d[6:0] == 7'h59) ? 7'h5a : d[6:0];
    load(8'h80, 3'h1, {24'h00_0000, na, 1'b0});
    frame(32'h0000_0001, 3'b010);
    `CHK("new_addr", na, tgt.addr)
    rd(twsp_pkg::REG_TARGET);
    `CHK("target", na, v[6:0])
    frame(32'h0000_0002, 3'b010);
    rd(twsp_pkg::REG_RDATA);
    `CHK("rdata", {24'h00_0000, na, 1'b0}, v)
    @(posedge clk) pwr_n <= 1'b0;
    @(posedge clk) pwr_n <= 1'b1;
    s0 = tgt.starts;
    frame(32'h0000_0001, 3'b110);
    `CHK("tries", 2, tgt.starts - s0)
    wr(twsp_pkg::REG_TARGET, 32'h0000_0059);
    frame(32'h0000_0001, 3'b010);
    $display("test address done");
    refuse <= 1'b1;
    frame(32'h0000_0002, 3'b110);
    refuse <= 1'b0;
    $display("test refuse done");
    close_out();
  end
endmodule
